//--- hw/spi_eeprom_pkg.sv
// package for the serial eeprom pin-protocol block
// assumes one core clock at 20 MHz and a host-driven serial clock
package spi_eeprom_pkg;

    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD   = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD  = 8'h01;
    localparam logic [7:0] CMD_READ          = 8'h03;
    localparam logic [7:0] CMD_WRITE         = 8'h02;

    // ------------------------------------------------------------
    // frame layout, in serial clock edges
    // ------------------------------------------------------------
    localparam int          CNT_W          = 6;
    localparam logic [5:0]  OP_BITS        = 6'h08;
    localparam logic [5:0]  STATUS_WR_BITS = 6'h10;
    localparam logic [5:0]  ADDR_LAST_BIT  = 6'h17;
    localparam logic [5:0]  WRITE_BITS     = 6'h20;
    localparam int          ADDR_W         = 12;

    // ------------------------------------------------------------
    // status byte fields
    // ------------------------------------------------------------
    localparam int BUSY_BIT = 0;
    localparam int WEL_BIT  = 1;
    localparam int BP0_BIT  = 2;
    localparam int BP1_BIT  = 3;
    localparam int PGE_BIT  = 7;
    localparam logic [2:0] LAST_BIT_IDX = 3'h7;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ             = 20000000;
    localparam longint WRITE_CYCLE_TIME_MS = 5;
    localparam longint WRITE_CYCLE_CYCLES  = WRITE_CYCLE_TIME_MS * CLK_HZ / 1000;
    localparam int     WC_CNT_W            = 17;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } mem_write_s;

endpackage : spi_eeprom_pkg

//--- hw/spi_eeprom_pins.sv
// serial eeprom interface logic at its pins: framing, status, write cycle
// assumes the memory array sits outside and drains mem_write_s words
//
// Summary of operation
// - serial input bits are captured on rising serial clock edges.
// - serial output changes on falling serial clock edges.
// - chip select high floats output; a running write cycle still completes.
// - write-guard pin high never blocks writes.
// - guard pin low with pin-guard enable set refuses status writes.
// - pause low freezes the transfer in place; release resumes it.
// - write cycle lasts 5 ms, starting within three core clocks of the closing chip select rise.
// - during a write cycle only status reads are honoured.
// - busy flag reads 1 during a write cycle, 0 after.
// - status write changes only bits 2, 3 and 7.
`timescale 1ns/10ps
`default_nettype none

module spi_eeprom_pins
    import spi_eeprom_pkg::*;
#(
    parameter int WRITE_CYCLE_CNT = int'(WRITE_CYCLE_CYCLES)
) (
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire logic                      sck,
    input  wire logic                      csN,
    input  wire logic                      si,
    input  wire logic                      holdN,
    input  wire logic                      wpN,
    output logic                           soOut,
    output logic                           soOe,
    output logic                           memValid,
    input  wire logic                      memReady,
    output spi_eeprom_pkg::mem_write_s     memWord,
    output logic                           busy
);
    import spi_eeprom_pkg::*;

    // ------------------------------------------------------------
    // link side, on the serial clock
    // ------------------------------------------------------------
    logic             frameRst;
    logic             fresh_r;
    logic [CNT_W-1:0] bitCnt_r;
    logic [CNT_W-1:0] bitCntCur;
    logic [CNT_W-1:0] bitCnt_nxt;
    logic [31:0]      shift_r;
    logic [31:0]      shiftCur;
    logic [7:0]       opcode_r;
    logic [15:0]      addr_r;
    logic             soBit_r;
    logic [7:0]       statusMeta_r;
    logic [7:0]       statusLink_r;
    logic [7:0]       statusByte;
    logic             statusReading;
    logic [2:0]       outIdx;

    // fields must outlive the closing chip select rise so the core can commit
    // them; deselect only marks the next frame fresh, restarting at bit one
    assign frameRst   = csN | ~reset_n;
    assign bitCntCur  = fresh_r ? '0 : bitCnt_r;
    assign shiftCur   = fresh_r ? '0 : shift_r;
    assign bitCnt_nxt = (bitCntCur == WRITE_BITS) ? bitCntCur : bitCntCur + 6'h01;

    always_ff @(posedge sck or posedge frameRst) begin
        if (frameRst) begin
            fresh_r <= 1'b1;
        end else if (holdN) begin
            fresh_r <= 1'b0;
        end
    end

    always_ff @(posedge sck or negedge reset_n) begin
        if (!reset_n) begin
            bitCnt_r <= '0;
            shift_r  <= '0;
            opcode_r <= '0;
            addr_r   <= '0;
        end else if (holdN && !csN) begin
            shift_r  <= {shiftCur[30:0], si};
            bitCnt_r <= bitCnt_nxt;
            if (fresh_r) begin
                opcode_r <= '0;
            end
            if (bitCntCur == OP_BITS - 6'h01) begin
                opcode_r <= {shiftCur[6:0], si};
            end
            if (bitCntCur == ADDR_LAST_BIT) begin
                addr_r <= {shiftCur[14:0], si};
            end
        end
    end

    // status level brought onto the serial clock; fresh after the opcode edges
    always_ff @(posedge sck or negedge reset_n) begin
        if (!reset_n) begin
            statusMeta_r <= '0;
            statusLink_r <= '0;
        end else begin
            statusMeta_r <= statusByte;
            statusLink_r <= statusMeta_r;
        end
    end

    // a fresh frame still holds the last frame's opcode until its first edge clears it
    assign statusReading = ~fresh_r && (opcode_r == STATUS_READ_CMD) && (bitCnt_r >= OP_BITS);
    assign outIdx        = LAST_BIT_IDX - bitCnt_r[2:0];

    always_ff @(negedge sck or posedge frameRst) begin
        if (frameRst) begin
            soBit_r <= 1'b0;
        end else if (holdN) begin
            soBit_r <= statusLink_r[outIdx];
        end
    end

    // status byte repeats until the edge count stops at 32; bit 7 then holds
    assign soOut = soBit_r;
    // floats when deselected, paused or nothing to send
    assign soOe  = ~csN & holdN & statusReading;

    // ------------------------------------------------------------
    // core side synchronisers
    // ------------------------------------------------------------
    logic csMeta_r, csSync_r, csPrev_r;
    logic wpMeta_r, wpSync_r;
    logic frameEnd;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            csMeta_r <= 1'b1;
            csSync_r <= 1'b1;
            csPrev_r <= 1'b1;
            wpMeta_r <= 1'b1;
            wpSync_r <= 1'b1;
        end else begin
            csMeta_r <= csN;
            csSync_r <= csMeta_r;
            csPrev_r <= csSync_r;
            wpMeta_r <= wpN;
            wpSync_r <= wpMeta_r;
        end
    end

    // frame fields are static once chip select is high: the serial clock
    // has stopped, so they are read only at the synchronised rise
    assign frameEnd = csSync_r & ~csPrev_r;

    // ------------------------------------------------------------
    // command commit at frame end
    // ------------------------------------------------------------
    logic       wel_r, pge_r, busy_r;
    logic [1:0] bp_r;
    logic [WC_CNT_W-1:0] wcCnt_r;
    logic       fifoFull;
    logic       guardActive, isWren, isWrdi, doStatusWr, doWrite, wcDone;
    logic [7:0] lastByte;
    mem_write_s newWord;

    function automatic logic inProtected(input logic [1:0] bp,
                                         input logic [ADDR_W-1:0] a);
        unique case (bp)
            2'h0:    inProtected = 1'b0;
            2'h1:    inProtected = a[11] & a[10];
            2'h2:    inProtected = a[11];
            2'h3:    inProtected = 1'b1;
        endcase
    endfunction : inProtected

    assign lastByte    = shift_r[7:0];
    // pin high never guards; low guards only with the enable bit set
    assign guardActive = ~wpSync_r & pge_r;
    // while busy every command is dropped; status reads need no commit
    assign isWren      = frameEnd & ~busy_r & (opcode_r == CMD_WRITE_ENABLE);
    assign isWrdi      = frameEnd & ~busy_r & (opcode_r == CMD_WRITE_DISABLE);
    assign doStatusWr  = frameEnd & ~busy_r & wel_r & ~guardActive
                         & (opcode_r == STATUS_WRITE_CMD) & (bitCnt_r >= STATUS_WR_BITS);
    assign doWrite     = frameEnd & ~busy_r & wel_r & ~fifoFull
                         & (opcode_r == CMD_WRITE) & (bitCnt_r == WRITE_BITS)
                         & ~inProtected(bp_r, addr_r[ADDR_W-1:0]);
    assign wcDone      = busy_r && (wcCnt_r == WC_CNT_W'(WRITE_CYCLE_CNT - 1));
    assign newWord     = '{addr: addr_r[ADDR_W-1:0], data: lastByte};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wel_r <= 1'b0;
            pge_r <= 1'b0;
            bp_r  <= 2'h0;
        end else begin
            if (isWren) begin
                wel_r <= 1'b1;
            end else if (isWrdi || wcDone) begin
                wel_r <= 1'b0;
            end
            if (doStatusWr) begin
                pge_r <= lastByte[PGE_BIT];
                bp_r  <= {lastByte[BP1_BIT], lastByte[BP0_BIT]};
            end
        end
    end

    // self-timed cycle runs on the core clock, not the stopped serial clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_r  <= 1'b0;
            wcCnt_r <= '0;
        end else if (doStatusWr || doWrite) begin
            busy_r  <= 1'b1;
            wcCnt_r <= '0;
        end else if (wcDone) begin
            busy_r  <= 1'b0;
        end else if (busy_r) begin
            wcCnt_r <= wcCnt_r + WC_CNT_W'(1);
        end
    end

    assign statusByte = {pge_r, 3'h0, bp_r, wel_r, busy_r};
    assign busy       = busy_r;

    // ------------------------------------------------------------
    // two-entry buffer toward the array
    // ------------------------------------------------------------
    mem_write_s fifoMem_r [2];
    logic       wrPtr_r, rdPtr_r;
    logic [1:0] fifoCnt_r;
    logic       push, pop;

    // a full buffer refuses the write, so a stalled array loses no word
    assign fifoFull = (fifoCnt_r == 2'h2);
    assign push     = doWrite;
    assign pop      = memValid & memReady;
    assign memValid = (fifoCnt_r != 2'h0);
    assign memWord  = fifoMem_r[rdPtr_r];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_r   <= 1'b0;
            rdPtr_r   <= 1'b0;
            fifoCnt_r <= 2'h0;
        end else begin
            if (push) begin
                wrPtr_r <= ~wrPtr_r;
            end
            if (pop) begin
                rdPtr_r <= ~rdPtr_r;
            end
            fifoCnt_r <= fifoCnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fifoMem_r[0] <= '0;
            fifoMem_r[1] <= '0;
        end else if (push) begin
            fifoMem_r[wrPtr_r] <= newWord;
        end
    end

endmodule : spi_eeprom_pins

`default_nettype wire

//--- test/spi_eeprom_pins_properties.sv
// checker for the eeprom pin block, bound to its top module
// assumes clk and sck domains share reset_n
`timescale 1ns/10ps
`default_nettype none
module spi_eeprom_pins_properties
    import spi_eeprom_pkg::*;
#(
    parameter int WRITE_CYCLE_CNT = 20
) (
    input wire logic                  clk,
    input wire logic                  reset_n,
    input wire logic                  sck,
    input wire logic                  csN,
    input wire logic                  si,
    input wire logic                  holdN,
    input wire logic                  wpN,
    input wire logic                  soOut,
    input wire logic                  soOe,
    input wire logic                  memValid,
    input wire logic                  memReady,
    input wire spi_eeprom_pkg::mem_write_s memWord,
    input wire logic                  busy
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic [16:0] busyCnt_r;
    logic        soAtRise_r;
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n) busyCnt_r <= 17'h0;
        else busyCnt_r <= busy ? busyCnt_r + 17'h1 : 17'h0;
    always_ff @(posedge sck or negedge reset_n)
        if (!reset_n) soAtRise_r <= 1'b0;
        else soAtRise_r <= soOut;
    sequence wordStall;
        memValid && !memReady;
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_oe_deselect: assert property (@(posedge clk) disable iff (!reset_n) csN |-> !soOe)
        else $error("output driven while deselected");
    a_oe_pause: assert property (@(posedge clk) disable iff (!reset_n) !holdN |-> !soOe)
        else $error("output driven while paused");
    a_so_falling: assert property (@(negedge sck) disable iff (!reset_n) soOut == soAtRise_r)
        else $error("serial output moved on rising clock");
    a_busy_bound: assert property (@(posedge clk) disable iff (!reset_n)
        busy |-> busyCnt_r < WRITE_CYCLE_CNT + 4) else $error("write cycle too long");
    a_word_stall: assert property (@(posedge clk) disable iff (!reset_n)
        wordStall |=> memValid && $stable(memWord)) else $error("stalled word lost");
    a_commit_idle: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(memValid) |-> csN && $past(csN, 2)) else $error("commit inside a frame");
    a_busy_idle: assert property (@(posedge clk) disable iff (!reset_n) $rose(busy) |-> csN)
        else $error("write cycle started inside a frame");
    a_word_busy: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(memValid) |-> ##[0:1] busy) else $error("word without busy");
endmodule : spi_eeprom_pins_properties
bind spi_eeprom_pins spi_eeprom_pins_properties #(.WRITE_CYCLE_CNT(WRITE_CYCLE_CNT))
    spi_eeprom_pins_properties_inst (.clk(clk), .reset_n(reset_n), .sck(sck), .csN(csN),
    .si(si), .holdN(holdN), .wpN(wpN), .soOut(soOut), .soOe(soOe), .memValid(memValid),
    .memReady(memReady), .memWord(memWord), .busy(busy));
`default_nettype wire

//--- test/spi_host_model.sv
// host side of the serial link, mode 0, 6 ns serial clock
// assumes the bench calls xfer and supplies the device output pins
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
    output logic      sck,
    output logic      csN,
    output logic      si,
    output logic      holdN,
    input wire logic  soOut,
    input wire logic  soOe
);
    initial begin
        sck = 1'b0;
        csN = 1'b1;
        si = 1'b0;
        holdN = 1'b1;
    end
    // pauseAt below zero means no pause; clock stands still between frames
    task automatic xfer(input logic [31:0] d, input int n, input int pauseAt,
                        output logic [7:0] rx);
        rx = 8'h00;
        csN = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si = d[i];
            #3 sck = 1'b1;
            rx = {rx[6:0], soOe ? soOut : ~rx[0]};
            #3 sck = 1'b0;
            if (i == pauseAt) begin
                #1 holdN = 1'b0;
                si = ~si;
                #2 sck = 1'b1;
                #3 sck = 1'b0;
                #1 holdN = 1'b1;
            end
        end
        si = ~si;
        #3 csN = 1'b1;
        #600;
    endtask : xfer
endmodule : spi_host_model
`default_nettype wire

//--- test/spi_eeprom_pins_test.sv
// self-checking bench for the eeprom pin block
// assumes a short write cycle count for simulation
`timescale 1ns/10ps
`default_nettype none
module spi_eeprom_pins_test;
    import spi_eeprom_pkg::*;
    // long enough that a command sent while busy lands inside the cycle
    localparam int WC = 60;
    // power-up wait, shortened for simulation
    localparam int POWERUP_WAIT = 10;
    logic clk = 1'b0, reset_n = 1'b0, wpN = 1'b1, memReady = 1'b0;
    logic sck, csN, si, holdN, soOut, soOe, memValid, busy;
    logic [7:0] rx;
    mem_write_s memWord, w;
    mem_write_s expQ[$];
    int mismatches = 0, tests_run = 0, seed = 98, cycles = 0;
    always #25 clk = ~clk;
    spi_eeprom_pins #(.WRITE_CYCLE_CNT(WC)) spi_eeprom_pins_inst (.clk(clk),
        .reset_n(reset_n), .sck(sck), .csN(csN), .si(si), .holdN(holdN), .wpN(wpN),
        .soOut(soOut), .soOe(soOe), .memValid(memValid), .memReady(memReady),
        .memWord(memWord), .busy(busy));
    spi_host_model spi_host_model_inst (.sck(sck), .csN(csN), .si(si), .holdN(holdN),
        .soOut(soOut), .soOe(soOe));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task print_verdict;
        $display("checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    task automatic send(input logic [31:0] d, input int n, input int p);
        spi_host_model_inst.xfer(d, n, p, rx);
    endtask : send
    task automatic waitBusy(input logic lvl);
        for (int i = 0; i < 300 && busy !== lvl; i++) @(negedge clk);
        check(busy, lvl);
    endtask : waitBusy
    // random stalls by the array side, and the hang limit
    always @(posedge clk) begin
        memReady <= $random(seed);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
        if (memValid === 1'b1 && memReady === 1'b1) begin
            if (expQ.size() == 0) check(1, 0);
            else check(memWord, expQ.pop_front());
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        check({soOe, memValid, busy}, 3'h0);
        repeat (POWERUP_WAIT) @(posedge clk);
        for (int k = 0; k < 2; k++) begin
            w = mem_write_s'($random(seed));
            send({24'h0, CMD_WRITE_ENABLE}, 8, -1);
            expQ.push_back(w);
            send({CMD_WRITE, 4'h0, w.addr, w.data}, 32, k ? 13 : -1);
            waitBusy(1'b1);
            send({16'h0, STATUS_READ_CMD, 8'h00}, 16, -1);
            check(rx[0], 1'b1);
            send({CMD_WRITE, 4'h0, ~w.addr, w.data}, 32, -1);
            waitBusy(1'b0);
            send({16'h0, STATUS_READ_CMD, 8'h00}, 16, -1);
            check(rx, 8'h00);
        end
        $display("test done: writes");
        send({24'h0, CMD_WRITE_ENABLE}, 8, -1);
        send({16'h0, STATUS_WRITE_CMD, 8'hff}, 16, -1);
        waitBusy(1'b1);
        waitBusy(1'b0);
        send({16'h0, STATUS_READ_CMD, 8'h00}, 16, -1);
        check(rx, 8'h8c);
        @(posedge clk) wpN <= 1'b0;
        send({24'h0, CMD_WRITE_ENABLE}, 8, -1);
        send({16'h0, STATUS_WRITE_CMD, 8'h00}, 16, -1);
        send({16'h0, STATUS_READ_CMD, 8'h00}, 16, -1);
        check(rx, 8'h8e);
        @(posedge clk) wpN <= 1'b1;
        send({16'h0, STATUS_WRITE_CMD, 8'h00}, 16, -1);
        waitBusy(1'b1);
        waitBusy(1'b0);
        send({16'h0, STATUS_READ_CMD, 8'h00}, 16, -1);
        check(rx, 8'h00);
        $display("test done: status guard");
        repeat (20) @(posedge clk);
        check(expQ.size(), 0);
        $display("test done: drain");
        print_verdict();
    end
endmodule : spi_eeprom_pins_test
`default_nettype wire
